//--- common/code_option_pkg.sv
// constants for the configuration option word loader and decoder
package code_option_pkg;

  // storage geometry
  localparam int          WORD_W        = 13;
  localparam int          APB_AW        = 12;
  localparam int          APB_DW        = 32;
  localparam int          PROT_W        = 3;

  // register byte addresses
  localparam logic [11:0] ADDR_WORD0    = 12'h000;
  localparam logic [11:0] ADDR_WORD1    = 12'h004;
  localparam logic [11:0] ADDR_STATUS   = 12'h008;

  // field positions in option word 0
  localparam int          BIT_RSVD_TOP  = 12;
  localparam int          BIT_RSVD_NEXT = 11;
  localparam int          BIT_ERR_REC   = 10;
  localparam int          BIT_RSVD_LOW  = 9;
  localparam int          BIT_PERIOD    = 8;
  localparam int          BIT_WDT_OFF   = 7;
  localparam int          BIT_PKG       = 6;
  localparam int          BIT_HF        = 5;
  localparam int          BIT_OSC       = 4;
  localparam int          BIT_PWR       = 3;
  localparam int          PROT_MSB      = 2;
  localparam int          PROT_LSB      = 0;

  // reserved positions and blank values
  localparam logic [12:0] RSVD_ONES     = 13'h1800;
  localparam logic [12:0] RSVD_ZEROS    = 13'h0200;
  localparam logic [12:0] BLANK_WORD0   = 13'h1dff;
  localparam logic [12:0] BLANK_WORD1   = 13'h1fff;
  localparam logic [2:0]  PROT_OFF      = 3'h7;

  // status register bit positions
  localparam int          ST_DONE0      = 0;
  localparam int          ST_DONE1      = 1;
  localparam int          ST_RC         = 2;
  localparam int          ST_FAST       = 3;
  localparam int          ST_SLOW       = 4;
  localparam int          ST_LONG       = 5;
  localparam int          ST_WDT        = 6;
  localparam int          ST_PROT       = 7;
  localparam int          ST_ERR_REC    = 8;
  localparam int          ST_SMALL      = 9;
  localparam int          ST_PWR        = 10;
  localparam int          ST_W          = 11;

  // instruction period divider terminal counts
  localparam logic [1:0]  CNT_LAST_SHORT = 2'h1;
  localparam logic [1:0]  CNT_LAST_LONG  = 2'h3;
  localparam logic [1:0]  CNT_ZERO       = 2'h0;
  localparam logic [1:0]  CNT_ONE        = 2'h1;

  typedef enum logic [1:0] {OSC_RC, OSC_FAST, OSC_SLOW, OSC_NONE} osc_mode_e;

endpackage

//--- hw/instr_period_divider.sv
// instruction cycle and timer clock divider, two or four oscillator periods
`timescale 1ns/1ps
module instr_period_divider (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // period choice, static after core reset
  input  wire logic longPeriod,
  // divided strobes
  output logic      cycleTick,
  output logic      timerTick
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       tick_q;
  wire  [1:0] lastCount = longPeriod ? code_option_pkg::CNT_LAST_LONG
                                     : code_option_pkg::CNT_LAST_SHORT;
  wire        atLast    = (cnt_q == lastCount);

  assign cnt_d = atLast ? code_option_pkg::CNT_ZERO : 2'(cnt_q + code_option_pkg::CNT_ONE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q  <= code_option_pkg::CNT_ZERO;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= atLast; // R6
    end
  end

  assign cycleTick = tick_q;
  // timer source runs at the instruction rate: fosc/2 or fosc/4
  assign timerTick = tick_q; // R15

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence longGap;
    timerTick ##1 !timerTick [*3] ##1 timerTick;
  endsequence
  sequence shortGap;
    timerTick ##1 !timerTick ##1 timerTick;
  endsequence

  a_long_timer_rate: assert property ( // R15
    (timerTick && longPeriod && $past(longPeriod) && $past(longPeriod, 2)
     && $past(longPeriod, 3) && $past(longPeriod, 4)) [*1] ##0 1'b1 |->
    $past(!timerTick) && $past(!timerTick, 2) && $past(!timerTick, 3) && $past(timerTick, 4))
    else $error("timer tick spacing wrong for four period cycle");
  a_short_cycle_rate: assert property ( // R6
    // the first tick after reset has no earlier tick to look back on
    (timerTick && !longPeriod && $past(!longPeriod) && $past(!longPeriod, 2)
     && $past(rst_n, 3)) |->
    $past(!timerTick) && $past(timerTick, 2))
    else $error("cycle tick spacing wrong for two period cycle");
  a_long_seq_form: assert property ( // R15
    (timerTick && longPeriod && $past(longPeriod)) |=> !timerTick)
    else $error("timer tick repeated back to back in four period mode");

endmodule

//--- hw/code_option_word_decoder.sv
// configuration option word store, apb programming port and option decoder
//
// Summary of operation
// R1 - the option words sit outside program memory and the core has no read or write path.
// R2 - storage is two 13-bit words, word 0 for options and word 1 for the customer id.
// R3 - bits 12 and 11 of word 0 are reserved and always hold one.
// R4 - bit 10 of word 0 low enables error recovery, high disables it.
// R5 - bit 9 of word 0 is reserved and always holds zero.
// R6 - bit 8 of word 0 picks a two (low) or four (high) oscillator period instruction cycle.
// R7 - bit 7 of word 0 low turns the watchdog on, high turns it off.
// R8 - bit 6 of word 0 low picks the large package variant, high the small one.
// R9 - bit 5 of word 0 picks slow (low) or fast (high) crystal, only with crystal type, else 0.
// R10 - bit 4 of word 0 low picks the external rc oscillator, high the crystal oscillator.
// R11 - bit 3 of word 0 low picks low drive power, high picks high drive power.
// R12 - code protection is off only when bits 2 to 0 are all one, on for any other value.
// R13 - source low gives rc mode, source and frequency high give fast crystal, source high
//       with frequency and power low gives slow crystal.
// R14 - word 1 is kept whole as a customer id with no effect on behaviour.
// R15 - with the four period cycle the timer clock is the oscillator divided by four.
// R16 - decoded options are taken during core reset and held constant after it.
`timescale 1ns/1ps
module code_option_word_decoder (
  // clock and power-on reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // core reset, options are sampled while it is low
  input  wire logic        coreRst_n,
  // writer attached, the only way into the words
  input  wire logic        progMode,
  // apb programming port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // decoded oscillator settings
  output logic             rcClockMode,
  output logic             fastCrystalMode,
  output logic             slowCrystalMode,
  output logic             drivePowerHigh,
  // decoded core settings
  output logic             longInstrPeriod,
  output logic             watchdogOn,
  output logic             errorRecoveryOn,
  output logic             smallPackage,
  output logic             codeProtectOn,
  output logic      [12:0] customerId,
  // divided strobes
  output logic             instrCycleTick,
  output logic             timerClockTick
);

  // ---------------------------------------------------------------- storage
  logic [12:0]                     word0_q;
  logic [12:0]                     word1_q;
  logic                            done0_q;
  logic                            done1_q;
  logic [31:0]                     rdata_q;
  logic                            err_q;

  // ---------------------------------------------------------------- held settings
  code_option_pkg::osc_mode_e      oscMode_q;
  code_option_pkg::osc_mode_e      oscMode_d;
  logic                            long_q;
  logic                            wdtOn_q;
  logic                            errRec_q;
  logic                            small_q;
  logic                            pwrHigh_q;
  logic                            prot_q;
  logic [12:0]                     id_q;

  // ---------------------------------------------------------------- bus decode
  wire        setupPhase  = psel & ~penable;
  wire        accessPhase = psel & penable;
  wire        hitWord0    = (paddr == code_option_pkg::ADDR_WORD0);
  wire        hitWord1    = (paddr == code_option_pkg::ADDR_WORD1);
  wire        hitStatus   = (paddr == code_option_pkg::ADDR_STATUS);
  wire        mapped      = hitWord0 | hitWord1 | hitStatus;
  wire [12:0] wrWord      = pwdata[code_option_pkg::WORD_W-1:0];

  // crystal frequency bit may only be set with crystal type selected
  wire        hfIllegal   = ~wrWord[code_option_pkg::BIT_OSC] & wrWord[code_option_pkg::BIT_HF];

  // each word is one-time programmable: a second write is refused
  wire        wr0Refused  = hitWord0 & (done0_q | hfIllegal);
  wire        wr1Refused  = hitWord1 & done1_q;
  wire        wrRefused   = hitStatus | wr0Refused | wr1Refused;

  // without the writer every access is refused, so core code cannot reach the words
  wire        refused     = ~progMode | ~mapped | (pwrite & wrRefused); // R1 R9

  wire        wrWord0     = accessPhase & pwrite & hitWord0 & progMode & ~wr0Refused; // R2
  wire        wrWord1     = accessPhase & pwrite & hitWord1 & progMode & ~wr1Refused; // R2

  // reserved positions forced whatever the writer sends
  wire [12:0] word0Clean  = (wrWord | code_option_pkg::RSVD_ONES)
                            & ~code_option_pkg::RSVD_ZEROS; // R3 R5

  // ---------------------------------------------------------------- option fields
  wire        srcCrystal  = word0_q[code_option_pkg::BIT_OSC];  // R10
  wire        freqHigh    = word0_q[code_option_pkg::BIT_HF];   // R9
  wire        powerHigh   = word0_q[code_option_pkg::BIT_PWR];  // R11
  wire [2:0]  protBits    = word0_q[code_option_pkg::PROT_MSB:code_option_pkg::PROT_LSB];
  wire        protActive  = (protBits != code_option_pkg::PROT_OFF); // R12
  wire        wdtEnable   = ~word0_q[code_option_pkg::BIT_WDT_OFF];  // R7
  wire        errRecEn    = ~word0_q[code_option_pkg::BIT_ERR_REC];  // R4
  wire        pkgSmall    = word0_q[code_option_pkg::BIT_PKG];       // R8
  wire        periodLong  = word0_q[code_option_pkg::BIT_PERIOD];    // R6

  // source low wins; frequency ignored for rc
  always_comb begin
    if (!srcCrystal) begin
      oscMode_d = code_option_pkg::OSC_RC; // R13
    end else if (freqHigh) begin
      oscMode_d = code_option_pkg::OSC_FAST; // R13 R9
    end else if (!powerHigh) begin
      oscMode_d = code_option_pkg::OSC_SLOW; // R13
    end else begin
      // slow crystal with high power is not a defined mode
      oscMode_d = code_option_pkg::OSC_NONE;
    end
  end

  // ---------------------------------------------------------------- read mux
  wire [code_option_pkg::ST_W-1:0] statusWord;
  assign statusWord[code_option_pkg::ST_DONE0]   = done0_q;
  assign statusWord[code_option_pkg::ST_DONE1]   = done1_q;
  assign statusWord[code_option_pkg::ST_RC]      = rcClockMode;
  assign statusWord[code_option_pkg::ST_FAST]    = fastCrystalMode;
  assign statusWord[code_option_pkg::ST_SLOW]    = slowCrystalMode;
  assign statusWord[code_option_pkg::ST_LONG]    = long_q;
  assign statusWord[code_option_pkg::ST_WDT]     = wdtOn_q;
  assign statusWord[code_option_pkg::ST_PROT]    = prot_q;
  assign statusWord[code_option_pkg::ST_ERR_REC] = errRec_q;
  assign statusWord[code_option_pkg::ST_SMALL]   = small_q;
  assign statusWord[code_option_pkg::ST_PWR]     = pwrHigh_q;

  wire [31:0] readMux = refused   ? 32'h0000_0000 :
                        hitWord0  ? {19'h0, word0_q} :
                        hitWord1  ? {19'h0, word1_q} :
                                    {21'h0, statusWord};

  // ---------------------------------------------------------------- bus registers
  // answer prepared in setup so prdata comes from a flop in the access cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (setupPhase) begin
      rdata_q <= pwrite ? 32'h0000_0000 : readMux; // R1
      err_q   <= refused;
    end
  end

  assign prdata  = rdata_q;
  assign pready  = accessPhase;
  assign pslverr = accessPhase & err_q;

  // ---------------------------------------------------------------- word store
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word0_q <= code_option_pkg::BLANK_WORD0;
      done0_q <= 1'b0;
    end else if (wrWord0) begin
      word0_q <= word0Clean; // R3 R5
      done0_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word1_q <= code_option_pkg::BLANK_WORD1;
      done1_q <= 1'b0;
    end else if (wrWord1) begin
      word1_q <= wrWord; // R14
      done1_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------- sampled settings
  // follows the words only while the core is in reset, frozen otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oscMode_q <= code_option_pkg::OSC_RC;
      long_q    <= 1'b0;
      wdtOn_q   <= 1'b0;
      errRec_q  <= 1'b0;
      small_q   <= 1'b0;
      pwrHigh_q <= 1'b0;
      prot_q    <= 1'b1;
      id_q      <= code_option_pkg::BLANK_WORD1;
    end else if (!coreRst_n) begin
      oscMode_q <= oscMode_d;  // R16
      long_q    <= periodLong; // R16
      wdtOn_q   <= wdtEnable;
      errRec_q  <= errRecEn;
      small_q   <= pkgSmall;
      pwrHigh_q <= powerHigh;
      prot_q    <= protActive;
      id_q      <= word1_q;    // R14
    end
  end

  assign rcClockMode     = (oscMode_q == code_option_pkg::OSC_RC);
  assign fastCrystalMode = (oscMode_q == code_option_pkg::OSC_FAST);
  assign slowCrystalMode = (oscMode_q == code_option_pkg::OSC_SLOW);
  assign drivePowerHigh  = pwrHigh_q;
  assign longInstrPeriod = long_q;
  assign watchdogOn      = wdtOn_q;
  assign errorRecoveryOn = errRec_q;
  assign smallPackage    = small_q;
  assign codeProtectOn   = prot_q;
  assign customerId      = id_q;

  // ---------------------------------------------------------------- divider
  instr_period_divider u_divider (
    .clk        (clk),
    .rst_n      (rst_n),
    .longPeriod (long_q),
    .cycleTick  (instrCycleTick),
    .timerTick  (timerClockTick)
  );

  // ---------------------------------------------------------------- checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence inCoreReset;
    !coreRst_n;
  endsequence
  sequence runningTwo;
    coreRst_n ##1 coreRst_n;
  endsequence

  a_rsvd_high_ones: assert property ( // R3
    word0_q[code_option_pkg::BIT_RSVD_TOP] && word0_q[code_option_pkg::BIT_RSVD_NEXT])
    else $error("reserved bits 12 and 11 of word 0 not one");
  a_rsvd_low_zero: assert property ( // R5
    wrWord0 |=> !word0_q[code_option_pkg::BIT_RSVD_LOW])
    else $error("reserved bit 9 of word 0 not zero");
  a_core_no_read: assert property ( // R1
    (setupPhase && !progMode) |=> (prdata == 32'h0000_0000) && pslverr == penable)
    else $error("word content visible without the writer");
  a_word_once: assert property ( // R2
    (done0_q && done1_q) |=> $stable(word0_q) && $stable(word1_q))
    else $error("programmed word changed");
  a_hold_running: assert property ( // R16
    runningTwo |-> $stable(oscMode_q) && $stable(long_q) && $stable(prot_q)
                   && $stable(wdtOn_q) && $stable(id_q))
    else $error("decoded option changed while core running");
  a_period_take: assert property ( // R6
    inCoreReset |=> long_q == $past(word0_q[code_option_pkg::BIT_PERIOD]))
    else $error("instruction period not taken from bit 8");
  a_wdt_polarity: assert property ( // R7
    inCoreReset |=> watchdogOn == !$past(word0_q[code_option_pkg::BIT_WDT_OFF]))
    else $error("watchdog enable polarity wrong");
  a_err_recovery: assert property ( // R4
    inCoreReset |=> errorRecoveryOn == !$past(word0_q[code_option_pkg::BIT_ERR_REC]))
    else $error("error recovery polarity wrong");
  a_pkg_power: assert property ( // R8
    inCoreReset |=> smallPackage == $past(word0_q[code_option_pkg::BIT_PKG])
                    && drivePowerHigh == $past(word0_q[code_option_pkg::BIT_PWR]))
    else $error("package or power select not taken");
  a_protect_decode: assert property ( // R12
    inCoreReset |=> codeProtectOn == ($past(protBits) != code_option_pkg::PROT_OFF))
    else $error("protection decode wrong");
  a_rc_mode: assert property ( // R10
    (inCoreReset and !srcCrystal) |=> rcClockMode && !fastCrystalMode && !slowCrystalMode)
    else $error("rc source did not give rc mode");
  a_crystal_modes: assert property ( // R13
    (inCoreReset and srcCrystal) |=>
      fastCrystalMode == $past(freqHigh)
      && slowCrystalMode == ($past(!freqHigh) && $past(!powerHigh)))
    else $error("crystal mode decode wrong");
  a_hf_refused: assert property ( // R9
    (setupPhase && pwrite && hitWord0 && hfIllegal) ##1 accessPhase |-> pslverr
      ##1 $stable(word0_q))
    else $error("frequency bit with rc type was accepted");
  a_id_copy: assert property ( // R14
    inCoreReset |=> customerId == $past(word1_q))
    else $error("customer id not copied from word 1");

  // bus side checks, pslverr judged at the access edge, stored words one edge after it
  sequence rdWord0Access;
    (setupPhase && !pwrite && hitWord0 && progMode) ##1 accessPhase;
  endsequence
  sequence rdWord1Access;
    (setupPhase && !pwrite && hitWord1 && progMode) ##1 accessPhase;
  endsequence

  a_read_word0: assert property ( // R2
    rdWord0Access |-> prdata == {19'h0, $past(word0_q)} && !pslverr)
    else $error("word 0 read back wrong");
  a_read_word1: assert property ( // R14
    rdWord1Access |-> prdata == {19'h0, $past(word1_q)} && !pslverr)
    else $error("word 1 read back wrong");
  a_word0_lands: assert property ( // R2
    wrWord0 |=> (word0_q | code_option_pkg::RSVD_ONES | code_option_pkg::RSVD_ZEROS)
                == ($past(wrWord) | code_option_pkg::RSVD_ONES | code_option_pkg::RSVD_ZEROS))
    else $error("option word not stored from the bus");
  a_word1_lands: assert property ( // R14
    wrWord1 |=> word1_q == $past(wrWord))
    else $error("customer id word not stored from the bus");
  a_rewrite0_refused: assert property ( // R2
    (setupPhase && pwrite && hitWord0 && done0_q) ##1 accessPhase |->
      pslverr ##1 $stable(word0_q))
    else $error("second write to option word accepted");
  a_rewrite1_refused: assert property ( // R2
    (setupPhase && pwrite && hitWord1 && done1_q) ##1 accessPhase |->
      pslverr ##1 $stable(word1_q))
    else $error("second write to customer id word accepted");
  a_no_writer_write: assert property ( // R1
    (accessPhase && pwrite && !progMode) |=> $stable(word0_q) && $stable(word1_q))
    else $error("word written without the writer attached");
  a_status_ro: assert property ( // R1
    (setupPhase && pwrite && hitStatus) ##1 accessPhase |-> pslverr)
    else $error("write to the status word not refused");
  a_unmapped_err: assert property ( // R2
    (setupPhase && !mapped) ##1 accessPhase |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_write_no_data: assert property ( // R1
    (setupPhase && pwrite) |=> prdata == 32'h0000_0000)
    else $error("write access returned word content");
  a_rc_hf_low: assert property ( // R9
    !(!word0_q[code_option_pkg::BIT_OSC] && word0_q[code_option_pkg::BIT_HF]))
    else $error("stored word has crystal frequency bit with rc type");

  // decode side checks
  a_undefined_mode: assert property ( // R13
    (inCoreReset and (srcCrystal && !freqHigh && powerHigh)) |=>
      !rcClockMode && !fastCrystalMode && !slowCrystalMode)
    else $error("undefined crystal setting gave an oscillator mode");
  a_hold_outputs: assert property ( // R16
    runningTwo |-> $stable(smallPackage) && $stable(drivePowerHigh)
                   && $stable(errorRecoveryOn))
    else $error("package, power or recovery setting changed while core running");
  a_safe_after_reset: assert property ( // R12
    $rose(rst_n) |-> codeProtectOn && customerId == code_option_pkg::BLANK_WORD1)
    else $error("protection or id not at blank state after reset");
  a_ticks_quiet_reset: assert property ( // R6
    $rose(rst_n) |-> !instrCycleTick && !timerClockTick)
    else $error("instruction tick raised at reset release");

endmodule

//--- verification/otp_writer_model.sv
// behavioural apb writer standing in for the one-time-programming tool
`timescale 1ns/1ps
module otp_writer_model (
  // clock
  input  wire logic        clk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released data must not linger as a stale match
    pwdata  <= ~d;
  endtask
endmodule

//--- verification/code_option_word_decoder_tb.sv
// self-checking bench for the option word store and decoder
`timescale 1ns/1ps
module code_option_word_decoder_tb;
  logic        clk, rst_n, coreRst_n, progMode;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        rcM, fastM, slowM, pwrHi, longP, wdOn, errOn, smallPk, protOn;
  logic        cycTick, tmrTick;
  logic [12:0] custId;
  logic [10:0] seenDec;
  int          fails, nTests;

  assign seenDec = {pwrHi, smallPk, errOn, protOn, wdOn, longP, slowM, fastM, rcM, 2'b00};

  code_option_word_decoder i_dut (
    .clk(clk), .rst_n(rst_n), .coreRst_n(coreRst_n), .progMode(progMode),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rcClockMode(rcM), .fastCrystalMode(fastM), .slowCrystalMode(slowM),
    .drivePowerHigh(pwrHi), .longInstrPeriod(longP), .watchdogOn(wdOn),
    .errorRecoveryOn(errOn), .smallPackage(smallPk), .codeProtectOn(protOn),
    .customerId(custId), .instrCycleTick(cycTick), .timerClockTick(tmrTick)
  );

  otp_writer_model i_writer (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_writer.xfer(w, a, d, rdat, err);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic core_pulse();
    @(posedge clk);
    coreRst_n <= 1'b0;
    @(posedge clk);
    coreRst_n <= 1'b1;
    @(posedge clk);
    #1;
  endtask

  // expected decode laid out like the status word
  function automatic logic [10:0] exp_dec(input logic [12:0] v);
    logic [10:0] e;
    e     = 11'h000;
    e[2]  = ~v[4];
    e[3]  = v[4] & v[5];
    e[4]  = v[4] & ~v[5] & ~v[3];
    e[5]  = v[8];
    e[6]  = ~v[7];
    e[7]  = (v[2:0] != 3'h7);
    e[8]  = ~v[10];
    e[9]  = v[6];
    e[10] = v[3];
    return e;
  endfunction

  task automatic t_reset_state();
    check({21'h0, seenDec}, 32'h0000_0084);
    check({19'h0, custId}, 32'h0000_1fff);
    bus(1'b0, code_option_pkg::ADDR_WORD0, 32'h0);
    check(rdat, 32'h0000_1dff);
    bus(1'b0, code_option_pkg::ADDR_WORD1, 32'h0);
    check(rdat, 32'h0000_1fff);
  endtask

  task automatic t_refusals();
    @(posedge clk);
    progMode <= 1'b0;
    bus(1'b0, code_option_pkg::ADDR_WORD0, 32'h0);
    check(rdat, 32'h0000_0000);
    check({31'h0, err}, 32'h1);
    bus(1'b1, code_option_pkg::ADDR_WORD1, 32'h0000_0123);
    check({31'h0, err}, 32'h1);
    progMode <= 1'b1;
    bus(1'b0, 12'h00c, 32'h0);
    check(rdat, 32'h0000_0000);
    check({31'h0, err}, 32'h1);
    bus(1'b1, code_option_pkg::ADDR_STATUS, 32'h0000_07ff);
    check({31'h0, err}, 32'h1);
    // rc source with fast crystal bit set is not a legal image
    bus(1'b1, code_option_pkg::ADDR_WORD0, 32'h0000_0020);
    check({31'h0, err}, 32'h1);
    bus(1'b0, code_option_pkg::ADDR_WORD0, 32'h0);
    check(rdat, 32'h0000_1dff);
  endtask

  task automatic t_period(input logic lng);
    int n;
    n = 0;
    // sample away from the launching edge so the tick has settled
    @(negedge clk);
    while (tmrTick !== 1'b1) @(negedge clk);
    do begin
      @(negedge clk);
      n++;
      check({31'h0, cycTick}, {31'h0, tmrTick});
    end while (tmrTick !== 1'b1 && n < 8);
    check(32'(n), lng ? 32'd4 : 32'd2);
  endtask

  task automatic t_config(input logic [12:0] v, input logic [12:0] id);
    logic [12:0] s;
    logic [10:0] e;
    s = (v | 13'h1800) & ~13'h0200;
    e = exp_dec(s);
    do_reset();
    // writer keeps the fast crystal bit low with rc source
    bus(1'b1, code_option_pkg::ADDR_WORD0, {19'h7ffff, v});
    check({31'h0, err}, 32'h0);
    bus(1'b0, code_option_pkg::ADDR_WORD0, 32'h0);
    check(rdat, {19'h0, s});
    core_pulse();
    check({21'h0, seenDec}, {21'h0, e});
    bus(1'b1, code_option_pkg::ADDR_WORD1, {19'h0, id});
    check({19'h0, custId}, 32'h0000_1fff);
    bus(1'b0, code_option_pkg::ADDR_STATUS, 32'h0);
    check(rdat, {21'h0, e | 11'h003});
    bus(1'b1, code_option_pkg::ADDR_WORD1, 32'h0000_0000);
    check({31'h0, err}, 32'h1);
    bus(1'b1, code_option_pkg::ADDR_WORD0, 32'h0000_0000);
    check({31'h0, err}, 32'h1);
    core_pulse();
    check({19'h0, custId}, {19'h0, id});
    check({21'h0, seenDec}, {21'h0, e});
    t_period(s[8]);
  endtask

  initial begin
    rst_n     = 1'b0;
    coreRst_n = 1'b1;
    progMode  = 1'b1;
    fails     = 0;
    nTests    = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_state();
    t_refusals();
    t_config(13'h0000, 13'h0abc);
    t_config(13'h07ff, 13'h1555);
    t_config(13'h0013, 13'h0000);
    t_config(13'h0018, 13'h1ff0);
    t_config(13'h0136, 13'h0f0f);
    tally_and_finish();
  end

  // well above the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
endmodule
